/* subchannel_slot_switch.sv */
// Subchannel time-slot switch: AXI4-Lite registers and link-side slot engine
`timescale 1ns/1ps
`default_nettype none
`include "subchannel_slot_switch_map.svh"

module subchannel_slot_switch (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  input  wire logic [7:0]                  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [7:0]                  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic                        link_clk,
  input  wire slot_switch_pkg::link_in_t   link_in,
  output var  slot_switch_pkg::link_out_t  link_out
);
  import slot_switch_pkg::*;

  // ----------------------------------------------------------------------
  // Code and position decoding
  // ----------------------------------------------------------------------
  function automatic logic [7:0] code_mask(input logic [3:0] code);
    case (code)
      `CODE_64K:     code_mask = 8'hff;
      `CODE_32K_B74: code_mask = 8'h0f;
      `CODE_16K_B10,
      `CODE_16K_B32,
      `CODE_16K_B76: code_mask = 8'h03;
      default:       code_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [2:0] hw_offset(input logic [3:0] code);
    case (code)
      `CODE_16K_B32: hw_offset = 3'h2;
      `CODE_32K_B74: hw_offset = 3'h4;
      `CODE_16K_B76: hw_offset = 3'h6;
      default:       hw_offset = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] sub_offset(input logic [1:0] pos, input logic [3:0] code);
    logic [2:0] off;
    off = 3'h0;
    if (code == `CODE_32K_B74) begin
      if (pos == `POS_MID) off = 3'h4;
    end else if (code_mask(code) == 8'h03) begin
      case (pos)
        `POS_MID:  off = 3'h2;
        `POS_HIGH: off = 3'h4;
        default:   off = 3'h0;
      endcase
    end
    sub_offset = off;
  endfunction

  function automatic op_t cmd_op(input logic [7:0] v);
    if (v[7:4] == `CMD_WR_FULL_HI) cmd_op = OP_WR_FULL;
    else if (v == `CMD_WR_PTR)     cmd_op = OP_WR_PTR;
    else if (v == `CMD_WR_TRI)     cmd_op = OP_WR_TRI;
    else if (v == `CMD_RD_PTR)     cmd_op = OP_RD_PTR;
    else if (v == `CMD_RD_CODE)    cmd_op = OP_RD_CODE;
    else                           cmd_op = OP_NONE;
  endfunction

  // ----------------------------------------------------------------------
  // Bus side: write channel and registers
  // ----------------------------------------------------------------------
  logic       aw_held, next_aw_held, w_held, next_w_held, w_strb0, next_w_strb0;
  logic [7:0] aw_addr, next_aw_addr, w_data, next_w_data;
  logic       next_bvalid;
  logic [1:0] next_bresp;
  logic [7:0] data_val, next_data_val, addr_sel, next_addr_sel;
  logic [7:0] cmd_val, next_cmd_val, pos_val, next_pos_val;
  logic       busy, next_busy, req_tog, next_req_tog, ack_seen, next_ack_seen;
  logic       ack_s1, ack_s2, ack_edge, wr_fire;
  req_t       req_q, next_req_q;
  logic [7:0] rd_result;
  logic       ack_tog;
  op_t        wr_op;

  assign awready  = ce && !aw_held && !bvalid;
  assign wready   = ce && !w_held && !bvalid;
  assign wr_fire  = aw_held && w_held && !bvalid;
  assign ack_edge = ack_s2 != ack_seen;
  assign wr_op    = cmd_op(w_data);

  // Capture channels, run register writes, launch memory commands
  always_comb begin
    next_aw_held  = aw_held;
    next_aw_addr  = aw_addr;
    next_w_held   = w_held;
    next_w_data   = w_data;
    next_w_strb0  = w_strb0;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_data_val = data_val;
    next_addr_sel = addr_sel;
    next_cmd_val  = cmd_val;
    next_pos_val  = pos_val;
    next_busy     = busy;
    next_req_tog  = req_tog;
    next_req_q    = req_q;
    next_ack_seen = ack_s2;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held  = 1'b1;
      next_w_data  = wdata[7:0];
      next_w_strb0 = wstrb[0];
    end
    if (bvalid && bready) next_bvalid = 1'b0;
    // Result lands in the data register as busy drops
    if (ack_edge) begin
      next_busy = 1'b0;
      if (req_q.op == OP_RD_PTR || req_q.op == OP_RD_CODE) next_data_val = rd_result;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `RESP_OKAY;
      case ({aw_addr[7:2], 2'h0})
        `OFF_DATA: if (w_strb0) next_data_val = w_data;
        `OFF_ADDR: if (w_strb0) next_addr_sel = w_addr_fix(w_data);
        `OFF_CMD: begin
          // Payload frozen in the request while busy; new commands refused meanwhile
          if (w_strb0 && !busy && wr_op != OP_NONE) begin
            next_cmd_val = w_data;
            next_req_q   = '{op: wr_op, addr: addr_sel, data: data_val, code: w_data[3:0]};
            next_req_tog = ~req_tog;
            next_busy    = 1'b1;
          end
        end
        `OFF_POS: begin
          if (w_strb0 && !busy) begin
            next_pos_val = w_data;
            next_req_q   = '{op: OP_POS, addr: addr_sel, data: w_data, code: 4'h0};
            next_req_tog = ~req_tog;
            next_busy    = 1'b1;
          end
        end
        `OFF_STATUS: ;
        default: next_bresp = `RESP_SLVERR;
      endcase
    end
  end

  function automatic logic [7:0] w_addr_fix(input logic [7:0] v);
    w_addr_fix = v;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      aw_addr  <= 8'h00;
      w_held   <= 1'b0;
      w_data   <= 8'h00;
      w_strb0  <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OKAY;
      data_val <= `DATA_RST;
      addr_sel <= `ADDR_RST;
      cmd_val  <= `CMD_RST;
      pos_val  <= `POS_RST;
      busy     <= 1'b0;
      req_tog  <= 1'b0;
      req_q    <= '{op: OP_NONE, addr: 8'h00, data: 8'h00, code: 4'h0};
      ack_seen <= 1'b0;
      ack_s1   <= 1'b0;
      ack_s2   <= 1'b0;
    end else if (ce) begin
      aw_held  <= next_aw_held;
      aw_addr  <= next_aw_addr;
      w_held   <= next_w_held;
      w_data   <= next_w_data;
      w_strb0  <= next_w_strb0;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      data_val <= next_data_val;
      addr_sel <= next_addr_sel;
      cmd_val  <= next_cmd_val;
      pos_val  <= next_pos_val;
      busy     <= next_busy;
      req_tog  <= next_req_tog;
      req_q    <= next_req_q;
      ack_seen <= next_ack_seen;
      ack_s1   <= ack_tog;
      ack_s2   <= ack_s1;
    end
  end

  // ----------------------------------------------------------------------
  // Bus side: read channel
  // ----------------------------------------------------------------------
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  assign arready = ce && !rvalid;

  // Registered read answer one cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && rready) next_rvalid = 1'b0;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case ({araddr[7:2], 2'h0})
        `OFF_DATA:   next_rdata[7:0] = data_val;
        `OFF_ADDR:   next_rdata[7:0] = addr_sel;
        `OFF_CMD:    next_rdata[7:0] = cmd_val;
        `OFF_POS:    next_rdata[7:0] = pos_val;
        `OFF_STATUS: next_rdata[`STATUS_BUSY_BIT] = busy;
        default:     next_rresp = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (ce) begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // ----------------------------------------------------------------------
  // Link side: synchronisers
  // ----------------------------------------------------------------------
  logic link_rs1, link_rstn, ce_s1, link_ce, req_s1, req_s2;

  // Reset, enable and request toggle brought onto the link clock
  always_ff @(posedge link_clk) begin
    link_rs1  <= aresetn;
    link_rstn <= link_rs1;
    ce_s1     <= ce;
    link_ce   <= ce_s1;
    req_s1    <= req_tog;
    req_s2    <= req_s1;
  end

  // ----------------------------------------------------------------------
  // Link side: memories and slot engine
  // ----------------------------------------------------------------------
  cm_entry_t  cm_dn [32];
  cm_entry_t  cm_up [32];
  logic [3:0] tri_mem [32];
  logic [7:0] dm_dn [32];
  logic [7:0] dm_up [32];
  logic [4:0] slot_q, cur_slot, cm_idx, up_slot;
  logic [7:0] pos_l, next_pos_l, next_rd_result;
  logic       req_seen, next_req_seen, next_ack_tog, exec;
  logic [1:0] pos;
  cm_entry_t  dn_e, up_e, cm_old, cm_wdata;
  logic [7:0] dn_m, dn_src, dn_field, sub_out;
  logic [7:0] up_m, up_src, up_field, up_old, up_new, up_hmask;
  logic [2:0] dn_so, up_so, up_ho;
  logic       up_we, cm_we_dn, cm_we_up, tri_we;
  logic [3:0] tri_cur;
  link_out_t  next_out;

  // Slot datapath and memory command execution
  always_comb begin
    cur_slot = link_in.frame_start ? 5'h00 : slot_q + 5'h01;
    pos      = pos_l[{cur_slot[4:3], 1'b0} +: 2];
    // Downstream: one entry per subscriber slot picks bits
    dn_e     = cm_dn[cur_slot];
    dn_m     = code_mask(dn_e.code);
    dn_so    = sub_offset(pos, dn_e.code);
    dn_src   = dn_e.up ? dm_up[dn_e.slot] : dm_dn[dn_e.slot];
    dn_field = (dn_src >> hw_offset(dn_e.code)) & dn_m;
    sub_out  = (8'hff & ~(dn_m << dn_so)) | (dn_field << dn_so);
    // Upstream: pointer with low top bit takes looped downstream data
    up_e     = cm_up[cur_slot];
    up_slot  = up_e.slot;
    up_m     = code_mask(up_e.code);
    up_so    = sub_offset(pos, up_e.code);
    up_ho    = hw_offset(up_e.code);
    up_src   = up_e.up ? link_in.sub_rx : sub_out;
    up_field = (up_src >> up_so) & up_m;
    up_old   = dm_up[up_slot];
    up_hmask = up_m << up_ho;
    up_we    = link_ce && (up_m != 8'h00);
    // Merge only the coded bits, others kept
    up_new   = (up_old & ~up_hmask) | (up_field << up_ho);
    tri_cur  = tri_mem[cur_slot];
    next_out.sub_tx     = sub_out;
    next_out.hw_tx      = dm_up[cur_slot];
    next_out.hw_tx_oe_n = ~tri_cur;
    exec           = link_ce && (req_s2 != req_seen);
    next_req_seen  = exec ? req_s2 : req_seen;
    next_ack_tog   = exec ? ~ack_tog : ack_tog;
    next_rd_result = rd_result;
    next_pos_l     = pos_l;
    cm_idx   = req_q.addr[4:0];
    cm_old   = req_q.addr[`ADDR_UP_BIT] ? cm_up[cm_idx] : cm_dn[cm_idx];
    cm_wdata = cm_old;
    cm_we_dn = 1'b0;
    cm_we_up = 1'b0;
    tri_we   = 1'b0;
    if (exec) begin
      case (req_q.op)
        OP_WR_FULL, OP_WR_PTR: begin
          cm_wdata.up   = req_q.data[`PTR_UP_BIT];
          cm_wdata.slot = req_q.data[4:0];
          if (req_q.op == OP_WR_FULL) cm_wdata.code = req_q.code;
          cm_we_up = req_q.addr[`ADDR_UP_BIT];
          cm_we_dn = !req_q.addr[`ADDR_UP_BIT];
        end
        OP_WR_TRI:  tri_we = 1'b1;
        OP_RD_PTR:  next_rd_result = {cm_old.up, 2'h0, cm_old.slot};
        OP_RD_CODE: next_rd_result = {4'h0, cm_old.code};
        OP_POS:     next_pos_l = req_q.data;
        default:    ;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rstn) begin
      slot_q    <= 5'h1f;
      req_seen  <= 1'b0;
      ack_tog   <= 1'b0;
      rd_result <= 8'h00;
      pos_l     <= `POS_RST;
      link_out  <= '{hw_tx: 8'h00, hw_tx_oe_n: 4'hf, sub_tx: 8'hff};
      for (int i = 0; i < 32; i++) begin
        cm_dn[i]   <= '{up: 1'b0, slot: 5'h00, code: `CODE_UNASSIGNED};
        cm_up[i]   <= '{up: 1'b0, slot: 5'h00, code: `CODE_UNASSIGNED};
        tri_mem[i] <= `TRI_RST;
        dm_dn[i]   <= 8'hff;
        dm_up[i]   <= 8'hff;
      end
    end else if (link_ce) begin
      slot_q    <= cur_slot;
      req_seen  <= next_req_seen;
      ack_tog   <= next_ack_tog;
      rd_result <= next_rd_result;
      pos_l     <= next_pos_l;
      link_out  <= next_out;
      dm_dn[cur_slot] <= link_in.hw_rx;
      if (up_we) dm_up[up_slot] <= up_new;
      if (cm_we_dn) cm_dn[cm_idx] <= cm_wdata;
      if (cm_we_up) cm_up[cm_idx] <= cm_wdata;
      if (tri_we) tri_mem[cm_idx] <= req_q.data[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  code16_lo_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (link_ce && dn_e.code == `CODE_16K_B10) |=>
      (((link_out.sub_tx >> $past(dn_so)) & 8'h03) == ($past(dn_src) & 8'h03)))
    else $error("16k low pair not switched");
  code16_mid_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (link_ce && dn_e.code == `CODE_16K_B32) |=>
      (((link_out.sub_tx >> $past(dn_so)) & 8'h03) == (($past(dn_src) >> 2) & 8'h03)))
    else $error("16k bits 3..2 not switched");
  code32_hi_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (link_ce && dn_e.code == `CODE_32K_B74) |=>
      (((link_out.sub_tx >> $past(dn_so)) & 8'h0f) == (($past(dn_src) >> 4) & 8'h0f)))
    else $error("32k upper nibble not switched");
  code16_top_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (link_ce && dn_e.code == `CODE_16K_B76) |=>
      (((link_out.sub_tx >> $past(dn_so)) & 8'h03) == (($past(dn_src) >> 6) & 8'h03)))
    else $error("16k bits 7..6 not switched");
  tri_write_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (exec && req_q.op == OP_WR_TRI) |=>
      (tri_mem[$past(cm_idx)] == $past(req_q.data[3:0])))
    else $error("tristate field not written");
  pair_drive_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    link_ce |=> (link_out.hw_tx_oe_n == ~$past(tri_cur)))
    else $error("pair enable does not follow tristate field");
  position_mid_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (link_ce && dn_e.code == `CODE_16K_B10 && pos == `POS_MID) |=>
      (((link_out.sub_tx >> 2) & 8'h03) == ($past(dn_src) & 8'h03)))
    else $error("position 10 does not place 16k at bits 3..2");
  merge_keep_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    up_we |=> ((dm_up[$past(up_slot)] & ~$past(up_hmask)) == ($past(up_old) & ~$past(up_hmask)))
      && ((dm_up[$past(up_slot)] & $past(up_hmask)) == ($past(up_field) << $past(up_ho))))
    else $error("upstream merge disturbs other bits");
  loop_down_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (link_ce && dn_e.up && dn_e.code == `CODE_64K) |=> (link_out.sub_tx == $past(dn_src)))
    else $error("loop does not read the upstream data memory");
  unassigned_a: assert property (@(posedge link_clk) disable iff (!link_rstn)
    (link_ce && dn_e.code == `CODE_UNASSIGNED && up_e.code == `CODE_UNASSIGNED) |->
      !up_we ##1 (link_out.sub_tx == 8'hff))
    else $error("unassigned slot carries data");
  busy_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && $rose(busy)) |-> (busy && !ack_edge) [*2])
    else $error("busy dropped before the link answered");
  busy_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (busy && ce && ack_edge) |=> !busy)
    else $error("busy stuck after the link answered");

  loop_cov: cover property (@(posedge link_clk) disable iff (!link_rstn) up_we && !up_e.up);
  merge_cov: cover property (@(posedge link_clk) disable iff (!link_rstn)
    up_we && up_m == 8'h03);
  tri_cov: cover property (@(posedge link_clk) disable iff (!link_rstn)
    exec && req_q.op == OP_WR_TRI);
  read_cov: cover property (@(posedge aclk) disable iff (!aresetn)
    ack_edge && req_q.op == OP_RD_PTR);
endmodule
`default_nettype wire

/* subchannel_slot_switch_map.svh */
// Register offsets, field codes and reset values of the subchannel slot switch
`ifndef SUBCHANNEL_SLOT_SWITCH_MAP_SVH
`define SUBCHANNEL_SLOT_SWITCH_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_DATA        8'h00
`define OFF_ADDR        8'h04
`define OFF_CMD         8'h08
`define OFF_POS         8'h0c
`define OFF_STATUS      8'h10

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ADDR_UP_BIT     7
`define PTR_UP_BIT      7
`define STATUS_BUSY_BIT 0
`define DATA_RST        8'h00
`define ADDR_RST        8'h00
`define CMD_RST         8'h00
`define POS_RST         8'h00
`define TRI_RST         4'h0

// ----------------------------------------------------------------------
// Connection codes, commands, subscriber positions, bus answers
// ----------------------------------------------------------------------
`define CODE_UNASSIGNED 4'h0
`define CODE_64K        4'h1
`define CODE_32K_B74    4'h3
`define CODE_16K_B10    4'h4
`define CODE_16K_B32    4'h6
`define CODE_16K_B76    4'h7
`define CMD_WR_FULL_HI  4'h7
`define CMD_WR_PTR      8'h48
`define CMD_WR_TRI      8'h60
`define CMD_RD_PTR      8'hc8
`define CMD_RD_CODE     8'hf0
`define POS_LOW         2'h3
`define POS_MID         2'h2
`define POS_HIGH        2'h1
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* slot_switch_pkg.sv */
// Types shared by the subchannel slot switch
`default_nettype none
package slot_switch_pkg;
  typedef enum logic [5:0] {
    OP_NONE    = 6'h00,
    OP_WR_FULL = 6'h01,
    OP_WR_PTR  = 6'h02,
    OP_WR_TRI  = 6'h04,
    OP_RD_PTR  = 6'h08,
    OP_RD_CODE = 6'h10,
    OP_POS     = 6'h20
  } op_t;

  typedef struct packed {
    logic       up;
    logic [4:0] slot;
    logic [3:0] code;
  } cm_entry_t;

  typedef struct packed {
    op_t        op;
    logic [7:0] addr;
    logic [7:0] data;
    logic [3:0] code;
  } req_t;

  typedef struct packed {
    logic       frame_start;
    logic [7:0] hw_rx;
    logic [7:0] sub_rx;
  } link_in_t;

  typedef struct packed {
    logic [7:0] hw_tx;
    logic [3:0] hw_tx_oe_n;
    logic [7:0] sub_tx;
  } link_out_t;
endpackage
`default_nettype wire

/* link_far_end.sv */
// Far-end model: highway and subscriber ports offering one byte per slot
`timescale 1ns/1ps
`default_nettype none
module link_far_end (
  input  wire logic                      link_clk,
  output logic [4:0]                     slot,
  output var  slot_switch_pkg::link_in_t link_in
);
  import slot_switch_pkg::*;
  logic [7:0] hw_tab  [32];
  logic [7:0] sub_tab [32];
  logic [4:0] cnt = 5'h00;
  // ----------------------------------------
  // Free-running frame of 32 slots
  // ----------------------------------------
  // Slot counter; the marker on slot 0 keeps the switch aligned
  always @(posedge link_clk) begin
    cnt <= cnt + 5'h01;
  end
  assign slot = cnt;
  // Fixed bytes per slot, so frame delay never shows in results
  assign link_in = '{cnt == 5'h00, hw_tab[cnt], sub_tab[cnt]};
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the subchannel slot switch
`timescale 1ns/1ps
`default_nettype none
`include "subchannel_slot_switch_map.svh"
module testbench;
  import slot_switch_pkg::*;
  typedef struct {logic c; logic [31:0] d; logic [1:0] r;} rs_t;
  typedef struct {logic [4:0] s; link_out_t o;} lk_t;
  logic       aclk = 0, link_clk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic       awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, q;
  logic       awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  link_in_t   link_in;
  link_out_t  link_out;
  logic [4:0] slot, out_slot;
  logic [7:0] eh [32], es [32];
  logic [3:0] eo [32];
  int         fail_count = 0, n_compared = 0, cyc = 0, seed = 15;
  rs_t        rs_q [$];
  lk_t        lk_q [$];
  rs_t        er;
  lk_t        el;

  subchannel_slot_switch DUT (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .link_clk, .link_in, .link_out);
  link_far_end far (.link_clk, .slot, .link_in);

  // Clocks, phase-unrelated
  initial forever #12.5 aclk = ~aclk;
  initial begin
    #3;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      wrap_up();
    end
  end

  // Bus answers are matched against the oldest note
  always @(posedge aclk) if ((rvalid && rready) || (bvalid && bready)) begin
    er = rs_q.pop_front();
    check(32'(rvalid ? rresp : bresp), 32'(er.r), "resp");
    if (er.c) check(rdata, er.d, "rdata");
  end

  // Link outputs show the slot taken at the previous edge
  always @(posedge link_clk) out_slot <= slot;
  always @(negedge link_clk) if (lk_q.size() > 0 && lk_q[0].s == out_slot) begin
    el = lk_q.pop_front();
    check(32'(link_out), 32'(el.o), "link");
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ta, td;
    ta = 0;
    td = 0;
    rs_q.push_back('{1'b0, 32'h0, r});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin ta = 1; awvalid <= 0; end
      if (wvalid && wready) begin td = 1; wvalid <= 0; end
    end while (!(ta && td));
    bready <= 1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] d,
                    input logic [1:0] r);
    rs_q.push_back('{c, d, r});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    rready <= 1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    q = rdata;
  endtask

  // Memory command: wait for busy to drop before anything else
  task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    wr(`OFF_DATA, d, `RESP_OKAY);
    wr(`OFF_ADDR, a, `RESP_OKAY);
    wr(c == 8'h00 ? `OFF_POS : `OFF_CMD, c == 8'h00 ? d : c, `RESP_OKAY);
    do rd(`OFF_STATUS, 0, 0, `RESP_OKAY); while (q[0] !== 1'b0);
  endtask

  initial begin
    for (int i = 0; i < 32; i++) begin
      far.hw_tab[i] = 8'($random(seed));
      far.sub_tab[i] = 8'($random(seed));
      eh[i] = 8'hff;
      es[i] = 8'hff;
      eo[i] = 4'hf;
    end
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    repeat (4) @(posedge aclk);
    // Reset values and an unmapped word
    rd(`OFF_DATA, 1, 0, `RESP_OKAY);
    rd(`OFF_ADDR, 1, 0, `RESP_OKAY);
    rd(`OFF_POS, 1, 0, `RESP_OKAY);
    rd(`OFF_STATUS, 1, 0, `RESP_OKAY);
    rd(8'h14, 1, 0, `RESP_SLVERR);
    wr(8'h14, 8'h5a, `RESP_SLVERR);
    $display("test registers done");
    // Subchannel connections, loops and tristate
    cmd(8'h00, 8'h93, 8'h00);
    cmd(8'h83, 8'h84, 8'h74);
    cmd(8'h9f, 8'h84, 8'h76);
    cmd(8'h04, 8'h05, `CMD_WR_TRI);
    cmd(8'h17, 8'h03, 8'h73);
    cmd(8'h12, 8'h04, 8'h77);
    cmd(8'h08, 8'h84, 8'h71);
    cmd(8'h09, 8'h02, 8'h71);
    cmd(8'h89, 8'h06, 8'h71);
    // Downstream pairs at the low pair and, for port 3, moved to bits 3..2
    cmd(8'h1e, 8'h05, 8'h74);
    cmd(8'h01, 8'h05, 8'h76);
    // Loop slot 6 is left floating so it stays off the line
    cmd(8'h06, 8'h00, `CMD_WR_TRI);
    eh[4] = {6'h3f, far.sub_tab[3][1:0]};
    eh[4][3:2] = far.sub_tab[31][3:2];
    eo[4] = 4'ha;
    es[23] = {4'hf, far.hw_tab[3][7:4]};
    es[18] = {2'b11, far.hw_tab[4][7:6], 4'hf};
    es[8] = eh[4];
    es[9] = far.hw_tab[2];
    es[30] = {4'hf, far.hw_tab[5][1:0], 2'b11};
    es[1] = {6'h3f, far.hw_tab[5][3:2]};
    eh[6] = far.hw_tab[2];
    repeat (60) @(posedge aclk);
    for (int i = 0; i < 32; i++) lk_q.push_back('{5'(i), '{eh[i], eo[i], es[i]}});
    repeat (60) @(posedge aclk);
    check(lk_q.size(), 0, "link frame seen");
    $display("test switching done");
    // Pointer-only rewrite keeps the code; read back pointer and code
    cmd(8'h17, 8'h05, `CMD_WR_PTR);
    cmd(8'h17, 8'h00, `CMD_RD_PTR);
    rd(`OFF_DATA, 1, 32'h05, `RESP_OKAY);
    cmd(8'h17, 8'h00, `CMD_RD_CODE);
    rd(`OFF_DATA, 1, 32'h03, `RESP_OKAY);
    cmd(8'h9f, 8'h00, `CMD_RD_PTR);
    rd(`OFF_DATA, 1, 32'h84, `RESP_OKAY);
    cmd(8'h9f, 8'h00, `CMD_RD_CODE);
    rd(`OFF_DATA, 1, 32'h06, `RESP_OKAY);
    rd(`OFF_CMD, 1, 32'(`CMD_RD_CODE), `RESP_OKAY);
    rd(`OFF_POS, 1, 32'h93, `RESP_OKAY);
    $display("test readback done");
    wrap_up();
  end
endmodule
`default_nettype wire
